// ---- hw/fmc_defines.vh ----
// Offsets, field positions, codes and thresholds of the FIFO misc block
`ifndef FMC_DEFINES_VH
`define FMC_DEFINES_VH

// Register byte offsets
`define FMC_ADDR_MISC 12'h0f8
`define FMC_ADDR_IRQ_STAT 12'h200
`define FMC_ADDR_IRQ_MASK 12'h204
`define FMC_ADDR_ERR_CNT 12'h208

// Field positions, bit 00 of the word is Verilog bit 31
`define FMC_FMT_DIS_BIT 31
`define FMC_ERR_MSB 30
`define FMC_ERR_LSB 27
`define FMC_TXCS_MSB 24
`define FMC_TXCS_LSB 16
`define FMC_EVERY_BIT 15
`define FMC_EXT_MSB 13
`define FMC_EXT_LSB 12
`define FMC_RXCS_MSB 8
`define FMC_RXCS_LSB 0

// Reset values
`define FMC_MISC_RST 32'h0000_0000
`define FMC_MASK_RST 2'h0

// Error codes
`define FMC_ERR_NONE 4'h0
`define FMC_ERR_ARX_EMPTY 4'h1
`define FMC_ERR_ARX_PAUSED 4'h2
`define FMC_ERR_ATX_FULL 4'h3
`define FMC_ERR_IRX_EMPTY 4'h4
`define FMC_ERR_IRX_PAUSED 4'h5
`define FMC_ERR_ITX_FULL 4'h6
`define FMC_ERR_DRX_EMPTY 4'h7
`define FMC_ERR_DRX_PAUSED 4'h8
`define FMC_ERR_DRX_EARLY 4'h9
`define FMC_ERR_DTX_FULL 4'ha
`define FMC_ERR_DRX_PUSH 4'hc

// Interrupt status bits
`define FMC_IRQ_ERR_BIT 0
`define FMC_IRQ_REL_BIT 1

// DV transmit threshold in bytes
`define FMC_THR_BASE 480
`define FMC_THR_STEP_SHIFT 7

`endif

// ---- hw/fmc_dv_gate.v ----
// DV transmit fill threshold gate
`timescale 1ns/1ns
`include "fmc_defines.vh"

module fmc_dv_gate #(
  parameter LVL_W = 12
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  // Settings
  input wire dv_mode_i,
  input wire every_i,
  input wire [1:0] ext_i,
  // Transmit FIFO side
  input wire [LVL_W-1:0] level_i,
  input wire pkt_start_i,
  output wire release_o,
  output wire first_done_o
);

  localparam integer THR_BASE_INT = `FMC_THR_BASE;
  localparam [LVL_W-1:0] THR_BASE = THR_BASE_INT[LVL_W-1:0];

  reg first_done_q;
  wire [LVL_W-1:0] n_w;
  wire [LVL_W-1:0] thr_w;
  wire filled_w;

  // N of 0, 128, 256 or 384 bytes
  assign n_w = {{(LVL_W-2-`FMC_THR_STEP_SHIFT){1'b0}}, ext_i,
    {`FMC_THR_STEP_SHIFT{1'b0}}}; // R12
  assign thr_w = THR_BASE + n_w;
  assign filled_w = (level_i >= thr_w);

  // Settings ignored outside DV mode
  assign release_o = !dv_mode_i ? 1'b1 : // R13
    every_i ? filled_w : // R11
    (first_done_q | filled_w); // R10

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_done_q <= 1'b0;
    end else if (ce_i && dv_mode_i && pkt_start_i && release_o) begin
      first_done_q <= 1'b1; // R10
    end
  end

  assign first_done_o = first_done_q;

endmodule // fmc_dv_gate

// ---- hw/fmc_err_encode.v ----
// Illegal host access detection and error code selection
`timescale 1ns/1ns
`include "fmc_defines.vh"

module fmc_err_encode (
  // Event lines, index order gives priority
  input wire [10:0] ev_i,
  // Result
  output wire hit_o,
  output reg [3:0] code_o
);

  function [3:0] code_of;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: code_of = `FMC_ERR_ARX_EMPTY;
        4'h1: code_of = `FMC_ERR_ARX_PAUSED;
        4'h2: code_of = `FMC_ERR_ATX_FULL;
        4'h3: code_of = `FMC_ERR_IRX_EMPTY;
        4'h4: code_of = `FMC_ERR_IRX_PAUSED;
        4'h5: code_of = `FMC_ERR_ITX_FULL;
        4'h6: code_of = `FMC_ERR_DRX_EMPTY;
        4'h7: code_of = `FMC_ERR_DRX_PAUSED;
        4'h8: code_of = `FMC_ERR_DRX_EARLY;
        4'h9: code_of = `FMC_ERR_DTX_FULL;
        4'ha: code_of = `FMC_ERR_DRX_PUSH;
        default: code_of = `FMC_ERR_NONE;
      endcase
    end
  endfunction

  integer i;

  assign hit_o = |ev_i;

  // Lowest index wins
  always @* begin
    code_o = `FMC_ERR_NONE;
    for (i = 10; i >= 0; i = i - 1) begin
      if (ev_i[i]) begin
        code_o = code_of(i[3:0]);
      end
    end
  end

endmodule // fmc_err_encode

// ---- hw/fmc_top.v ----
// FIFO misc control and status register with host access error capture
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ns
`include "fmc_defines.vh"

// Overview of operation
// R01: Format-output disable bit high puts three bulk format lines in high-Z.
// R02: Read-only four-bit host access error code, zero after reset.
// R03: Async codes: 1h empty pop, 2h paused pop, 3h full push.
// R04: Isochronous codes: 4h empty pop, 5h paused pop, 6h full push.
// R05: DV codes: 7h empty pop, 8h paused pop, Ah full push.
// R06: DV receive pop before time-stamp release in application mode gives 9h.
// R07: DV receive push in application mode gives code Ch (7ch low nibble).
// R08: Nine-bit alternate transmit cell size, read-write, reset to zero.
// R09: Nine-bit alternate receive cell size, read-write, reset to zero.
// R10: Threshold select low holds only first DV packet until 480+N bytes.
// R11: Threshold select high holds every DV packet until 480+N bytes.
// R12: Extension field picks N of 0, 128, 256, 384 bytes; resets to 00.
// R13: Threshold settings act only in DV mode.
// R14: Bit 00 is the word MSB; fields count down from it.
// R15: Error code holds the last illegal access until overwritten or reset.
module fmc_top #(
  parameter LVL_W = 12,
  parameter AW = 12
) (
  // Clock, reset, enable
  input wire CLOCK_I,
  input wire RESET_N_I,
  input wire CE_I,
  // Wishbone slave
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [AW-1:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output wire [31:0] WB_DAT_O,
  output wire WB_ACK_O,
  // Interrupt
  output wire IRQ_O,
  // Asynchronous FIFO host accesses
  input wire ASYNC_RX_POP_I,
  input wire ASYNC_RX_EMPTY_I,
  input wire ASYNC_RX_PAUSED_I,
  input wire ASYNC_TX_PUSH_I,
  input wire ASYNC_TX_FULL_I,
  // Isochronous FIFO host accesses
  input wire ISO_RX_POP_I,
  input wire ISO_RX_EMPTY_I,
  input wire ISO_RX_PAUSED_I,
  input wire ISO_TX_PUSH_I,
  input wire ISO_TX_FULL_I,
  // DV FIFO host accesses
  input wire DV_RX_POP_I,
  input wire DV_RX_PUSH_I,
  input wire DV_RX_EMPTY_I,
  input wire DV_RX_PAUSED_I,
  input wire DV_RX_TO_APP_I,
  input wire DV_TS_RELEASED_I,
  input wire DV_TX_PUSH_I,
  input wire DV_TX_FULL_I,
  // DV transmit threshold
  input wire DV_MODE_I,
  input wire [LVL_W-1:0] DV_TX_LEVEL_I,
  input wire DV_TX_PKT_START_I,
  output wire DV_TX_RELEASE_O,
  // Bulk application interface format lines
  input wire [2:0] BULK_FMT_I,
  output wire [2:0] BULK_FMT_O,
  output wire [2:0] BULK_FMT_OE_O,
  // Cell sizes to the FIFO logic
  output wire [8:0] ALT_TX_CELL_SIZE_O,
  output wire [8:0] ALT_RX_CELL_SIZE_O
);

  localparam ST_IDLE = 2'b01;
  localparam ST_ACK = 2'b10;

  // Reset synchroniser
  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_n;

  always @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  assign rst_n = rst_s2_q;

  // Register state
  reg fmt_dis_q;
  reg fmt_dis_d;
  reg [3:0] err_q;
  reg [3:0] err_d;
  reg [8:0] txcs_q;
  reg [8:0] txcs_d;
  reg [8:0] rxcs_q;
  reg [8:0] rxcs_d;
  reg every_q;
  reg every_d;
  reg [1:0] ext_q;
  reg [1:0] ext_d;
  reg [1:0] stat_q;
  reg [1:0] stat_d;
  reg [1:0] mask_q;
  reg [1:0] mask_d;
  reg [15:0] err_cnt_q;
  reg [15:0] err_cnt_d;
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [31:0] rdat_q;
  reg [31:0] rdat_d;
  reg [2:0] fmt_q;
  reg rel_q;

  wire req_w;
  wire wr_w;
  wire rd_w;
  wire [31:0] misc_w;
  wire [10:0] ev_w;
  wire hit_w;
  wire [3:0] code_w;
  wire release_w;
  wire first_done_w;
  wire rel_rise_w;
  wire [1:0] stat_set_w;

  function [AW-1:0] word_addr;
    input [AW-1:0] a;
    begin
      word_addr = {a[AW-1:2], 2'b00};
    end
  endfunction

  function sel_hit;
    input [AW-1:0] a;
    input [AW-1:0] target;
    begin
      sel_hit = (word_addr(a) == target);
    end
  endfunction

  // Illegal host access events
  assign ev_w[0] = ASYNC_RX_POP_I & ASYNC_RX_EMPTY_I; // R03
  assign ev_w[1] = ASYNC_RX_POP_I & ~ASYNC_RX_EMPTY_I &
    ASYNC_RX_PAUSED_I; // R03
  assign ev_w[2] = ASYNC_TX_PUSH_I & ASYNC_TX_FULL_I; // R03
  assign ev_w[3] = ISO_RX_POP_I & ISO_RX_EMPTY_I; // R04
  assign ev_w[4] = ISO_RX_POP_I & ~ISO_RX_EMPTY_I &
    ISO_RX_PAUSED_I; // R04
  assign ev_w[5] = ISO_TX_PUSH_I & ISO_TX_FULL_I; // R04
  assign ev_w[6] = DV_RX_POP_I & DV_RX_EMPTY_I; // R05
  assign ev_w[7] = DV_RX_POP_I & ~DV_RX_EMPTY_I & DV_RX_PAUSED_I; // R05
  assign ev_w[8] = DV_RX_POP_I & ~DV_RX_EMPTY_I & ~DV_RX_PAUSED_I &
    DV_RX_TO_APP_I & ~DV_TS_RELEASED_I; // R06
  assign ev_w[9] = DV_TX_PUSH_I & DV_TX_FULL_I; // R05
  assign ev_w[10] = DV_RX_PUSH_I & DV_RX_TO_APP_I; // R07

  fmc_err_encode u_err (
    .ev_i(ev_w),
    .hit_o(hit_w),
    .code_o(code_w)
  );

  fmc_dv_gate #(
    .LVL_W(LVL_W)
  ) u_gate (
    .clk_i(CLOCK_I),
    .rst_n_i(rst_n),
    .ce_i(CE_I),
    .dv_mode_i(DV_MODE_I),
    .every_i(every_q),
    .ext_i(ext_q),
    .level_i(DV_TX_LEVEL_I),
    .pkt_start_i(DV_TX_PKT_START_I),
    .release_o(release_w),
    .first_done_o(first_done_w)
  );

  assign DV_TX_RELEASE_O = release_w;

  // Register image, bit 00 at bit 31
  assign misc_w = { // R14
    fmt_dis_q, // R01
    err_q, // R02
    2'b00,
    txcs_q, // R08
    every_q, // R11
    1'b0,
    ext_q, // R12
    3'b000,
    rxcs_q // R09
  };

  // Bus decode
  assign req_w = WB_CYC_I & WB_STB_I & (st_q == ST_IDLE);
  assign wr_w = req_w & WB_WE_I;
  assign rd_w = req_w & ~WB_WE_I;

  // Release edge in DV mode
  assign rel_rise_w = DV_MODE_I & release_w & ~rel_q;
  assign stat_set_w = {rel_rise_w, hit_w};

  // Bus slave state
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (WB_CYC_I && WB_STB_I) begin
          st_d = ST_ACK;
        end
      end
      ST_ACK: begin
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // Read data
  always @* begin
    rdat_d = rdat_q;
    if (rd_w) begin
      if (sel_hit(WB_ADR_I, `FMC_ADDR_MISC)) begin
        rdat_d = misc_w;
      end else if (sel_hit(WB_ADR_I, `FMC_ADDR_IRQ_STAT)) begin
        rdat_d = {30'h0, stat_q};
      end else if (sel_hit(WB_ADR_I, `FMC_ADDR_IRQ_MASK)) begin
        rdat_d = {30'h0, mask_q};
      end else if (sel_hit(WB_ADR_I, `FMC_ADDR_ERR_CNT)) begin
        rdat_d = {13'h0, first_done_w, rel_q, hit_w, err_cnt_q};
      end else begin
        rdat_d = 32'h0000_0000;
      end
    end
  end

  // Writable fields
  always @* begin
    fmt_dis_d = fmt_dis_q;
    txcs_d = txcs_q;
    rxcs_d = rxcs_q;
    every_d = every_q;
    ext_d = ext_q;
    mask_d = mask_q;
    if (wr_w && sel_hit(WB_ADR_I, `FMC_ADDR_MISC)) begin
      if (WB_SEL_I[3]) begin
        fmt_dis_d = WB_DAT_I[`FMC_FMT_DIS_BIT]; // R01
        txcs_d[8] = WB_DAT_I[`FMC_TXCS_MSB]; // R08
      end
      if (WB_SEL_I[2]) begin
        txcs_d[7:0] = WB_DAT_I[23:`FMC_TXCS_LSB]; // R08
      end
      if (WB_SEL_I[1]) begin
        every_d = WB_DAT_I[`FMC_EVERY_BIT]; // R11
        ext_d = WB_DAT_I[`FMC_EXT_MSB:`FMC_EXT_LSB]; // R12
        rxcs_d[8] = WB_DAT_I[`FMC_RXCS_MSB]; // R09
      end
      if (WB_SEL_I[0]) begin
        rxcs_d[7:0] = WB_DAT_I[7:`FMC_RXCS_LSB]; // R09
      end
    end
    if (wr_w && sel_hit(WB_ADR_I, `FMC_ADDR_IRQ_MASK) && WB_SEL_I[0]) begin
      mask_d = WB_DAT_I[1:0];
    end
  end

  // Error capture, status and count
  always @* begin
    err_d = err_q;
    err_cnt_d = err_cnt_q;
    stat_d = stat_q;
    if (hit_w) begin
      err_d = code_w; // R15
      if (err_cnt_q != 16'hffff) begin
        err_cnt_d = err_cnt_q + 16'h0001;
      end
    end
    if (rd_w && sel_hit(WB_ADR_I, `FMC_ADDR_IRQ_STAT)) begin
      stat_d = 2'b00;
    end
    stat_d = stat_d | stat_set_w;
  end

  always @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      rdat_q <= 32'h0000_0000;
      fmt_dis_q <= 1'b0; // R01
      err_q <= `FMC_ERR_NONE; // R02
      txcs_q <= 9'h000; // R08
      rxcs_q <= 9'h000; // R09
      every_q <= 1'b0; // R10
      ext_q <= 2'b00; // R12
      stat_q <= 2'b00;
      mask_q <= `FMC_MASK_RST;
      err_cnt_q <= 16'h0000;
      fmt_q <= 3'b000;
      rel_q <= 1'b0;
    end else if (CE_I) begin
      st_q <= st_d;
      rdat_q <= rdat_d;
      fmt_dis_q <= fmt_dis_d;
      err_q <= err_d; // R02
      txcs_q <= txcs_d;
      rxcs_q <= rxcs_d;
      every_q <= every_d;
      ext_q <= ext_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      err_cnt_q <= err_cnt_d;
      fmt_q <= BULK_FMT_I;
      rel_q <= DV_MODE_I & release_w;
    end
  end

  // Bus answer
  assign WB_ACK_O = (st_q == ST_ACK);
  assign WB_DAT_O = rdat_q;

  // Interrupt
  assign IRQ_O = |(stat_q & mask_q);

  // Format lines
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_fmt
      assign BULK_FMT_O[g] = fmt_q[g];
      assign BULK_FMT_OE_O[g] = ~fmt_dis_q; // R01
    end
  endgenerate

  // Cell sizes
  assign ALT_TX_CELL_SIZE_O = txcs_q;
  assign ALT_RX_CELL_SIZE_O = rxcs_q;

endmodule // fmc_top

// ---- test/fmc_host_model.sv ----
// Host software model issuing legal and illegal FIFO accesses
`timescale 1ns/1ns
module fmc_host_model (
  // Clock and command
  input wire clk_i,
  input wire go_i,
  input wire [3:0] kind_i,
  // FIFO strobes and status levels
  output reg [6:0] sb_o = 7'h0,
  output reg [10:0] st_o = 11'h400
);
  always @(posedge clk_i) begin
    sb_o <= 7'h0;
    st_o <= 11'h400;
    if (go_i) begin
      case (kind_i)
        4'h1: {sb_o, st_o} <= {7'h01, 11'h401};
        4'h2: {sb_o, st_o} <= {7'h01, 11'h402};
        4'h3: {sb_o, st_o} <= {7'h02, 11'h404};
        4'h4: {sb_o, st_o} <= {7'h04, 11'h408};
        4'h5: {sb_o, st_o} <= {7'h04, 11'h410};
        4'h6: {sb_o, st_o} <= {7'h08, 11'h420};
        4'h7: {sb_o, st_o} <= {7'h10, 11'h440};
        4'h8: {sb_o, st_o} <= {7'h10, 11'h480};
        4'h9: {sb_o, st_o} <= {7'h10, 11'h200};
        4'ha: {sb_o, st_o} <= {7'h40, 11'h500};
        4'hc: {sb_o, st_o} <= {7'h20, 11'h600};
        default: sb_o <= 7'h01;
      endcase
    end
  end
endmodule // fmc_host_model

// ---- test/fmc_top_monitor.sv ----
// Assertion checker bound to the FIFO misc block
`timescale 1ns/1ns
module fmc_top_monitor #(
  parameter LVL_W = 12,
  parameter AW = 12
) (
  // Clock, reset, enable
  input wire CLOCK_I,
  input wire RESET_N_I,
  input wire CE_I,
  // Bus
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [AW-1:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  input wire [31:0] WB_DAT_O,
  input wire WB_ACK_O,
  // Gate and outputs
  input wire DV_MODE_I,
  input wire [LVL_W-1:0] DV_TX_LEVEL_I,
  input wire DV_TX_PKT_START_I,
  input wire DV_TX_RELEASE_O,
  input wire [2:0] BULK_FMT_OE_O,
  input wire [8:0] ALT_TX_CELL_SIZE_O,
  input wire [8:0] ALT_RX_CELL_SIZE_O
);
  wire f8 = WB_ACK_O && WB_ADR_I == 12'h0f8;
  wire wr = f8 && WB_WE_I && WB_SEL_I == 4'hf;
  reg every_q;
  reg first_q;
  reg [1:0] ext_q;
  wire [12:0] thr = 13'd480 + {4'h0, ext_q, 7'h0};
  always @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      every_q <= 1'b0;
      ext_q <= 2'h0;
      first_q <= 1'b0;
    end else begin
      if (wr) begin
        every_q <= WB_DAT_I[15];
        ext_q <= WB_DAT_I[13:12];
      end
      if (CE_I && DV_MODE_I && DV_TX_PKT_START_I && DV_TX_RELEASE_O) begin
        first_q <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);
  ack_once_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  ack_take_a: assert property (WB_CYC_I && WB_STB_I && CE_I && !WB_ACK_O
    |=> WB_ACK_O) else $error("request not acked");
  ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  fmt_hiz_a: assert property (wr |->
    BULK_FMT_OE_O == {3{~WB_DAT_I[31]}}) else $error("format enables wrong");
  cell_size_a: assert property (wr |->
    ALT_TX_CELL_SIZE_O == WB_DAT_I[24:16] &&
    ALT_RX_CELL_SIZE_O == WB_DAT_I[8:0]) else $error("cell size wrong");
  resv_zero_a: assert property (f8 && !WB_WE_I |->
    (WB_DAT_O & 32'h0600_4e00) == 32'h0) else $error("unused bits set");
  dvoff_rel_a: assert property (!DV_MODE_I |-> DV_TX_RELEASE_O)
    else $error("gate active outside mode");
  thr_gate_a: assert property (!WB_ACK_O && DV_MODE_I &&
    (every_q || !first_q) |-> DV_TX_RELEASE_O == (DV_TX_LEVEL_I >= thr))
    else $error("threshold gate wrong");
  rd_cov: cover property (f8 && !WB_WE_I);
  rel_cov: cover property (DV_MODE_I && $rose(DV_TX_RELEASE_O));
  first_cov: cover property ($rose(first_q));
endmodule // fmc_top_monitor

bind fmc_top fmc_top_monitor #(.LVL_W(LVL_W), .AW(AW)) mon (.*);

// ---- test/fmc_top_tb_top.sv ----
// Self-checking bench for the FIFO misc block
`timescale 1ns/1ns
module fmc_top_tb_top;
  reg clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0;
  reg go = 1'b0, dv = 1'b0, pkt = 1'b0, ce = 1'b1;
  reg [3:0] kind = 4'h0, sel = 4'h0;
  reg [11:0] adr = 12'h0, lvl = 12'h0;
  reg [31:0] wd = 32'h0, rd;
  wire [31:0] q;
  wire ack, irq, rel;
  wire [2:0] oe, fmt;
  wire [6:0] sb;
  wire [10:0] st;
  integer errors = 0, n_compared = 0, i;
  fmc_host_model hm (.clk_i(clk), .go_i(go), .kind_i(kind), .sb_o(sb),
    .st_o(st));
  fmc_top dut (.CLOCK_I(clk), .RESET_N_I(rst_n), .CE_I(ce),
    .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(q), .WB_ACK_O(ack),
    .IRQ_O(irq), .ASYNC_RX_POP_I(sb[0]), .ASYNC_RX_EMPTY_I(st[0]),
    .ASYNC_RX_PAUSED_I(st[1]), .ASYNC_TX_PUSH_I(sb[1]),
    .ASYNC_TX_FULL_I(st[2]), .ISO_RX_POP_I(sb[2]), .ISO_RX_EMPTY_I(st[3]),
    .ISO_RX_PAUSED_I(st[4]), .ISO_TX_PUSH_I(sb[3]), .ISO_TX_FULL_I(st[5]),
    .DV_RX_POP_I(sb[4]), .DV_RX_PUSH_I(sb[5]), .DV_RX_EMPTY_I(st[6]),
    .DV_RX_PAUSED_I(st[7]), .DV_RX_TO_APP_I(st[9]),
    .DV_TS_RELEASED_I(st[10]), .DV_TX_PUSH_I(sb[6]), .DV_TX_FULL_I(st[8]),
    .DV_MODE_I(dv), .DV_TX_LEVEL_I(lvl), .DV_TX_PKT_START_I(pkt),
    .DV_TX_RELEASE_O(rel), .BULK_FMT_I(3'h5), .BULK_FMT_O(fmt),
    .BULK_FMT_OE_O(oe), .ALT_TX_CELL_SIZE_O(), .ALT_RX_CELL_SIZE_O());
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
    integer n;
    begin
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      sel <= s;
      n = 0;
      @(posedge clk);
      while (ack !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge clk);
      end
      if (n == 20) errors = errors + 1;
      rd = q;
      cyc <= 1'b0;
      we <= 1'b0;
    end
  endtask
  task hit(input [3:0] k);
    begin
      @(posedge clk);
      kind <= k;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  task t_regs;
    begin
      wb(1'b0, 12'h0f8, 32'h0, 4'hf);
      chk(rd, 32'h0);
      chk(oe, 32'h7);
      chk(fmt, 32'h5);
      wb(1'b1, 12'h0f8, 32'hffff_ffff, 4'hf);
      chk(oe, 32'h0);
      wb(1'b1, 12'h0f8, 32'h0, 4'h1);
      wb(1'b0, 12'h0f8, 32'h0, 4'hf);
      chk(rd, 32'h81ff_b100);
      wb(1'b0, 12'h0fc, 32'h0, 4'hf);
      chk(rd, 32'h0);
      wb(1'b1, 12'h0f8, 32'h0, 4'hf);
      chk(oe, 32'h7);
    end
  endtask
  task t_codes;
    begin
      for (i = 1; i < 13; i = i + 1) begin
        if (i != 11) begin
          hit(i[3:0]);
          wb(1'b0, 12'h0f8, 32'h0, 4'hf);
          chk(rd[30:27], i);
        end
      end
      hit(4'h0);
      wb(1'b0, 12'h0f8, 32'h0, 4'hf);
      chk(rd[30:27], 32'hc);
      ce <= 1'b0;
      hit(4'h3);
      ce <= 1'b1;
      wb(1'b0, 12'h0f8, 32'h0, 4'hf);
      chk(rd[30:27], 32'hc);
    end
  endtask
  task t_irq;
    begin
      wb(1'b1, 12'h204, 32'h1, 4'hf);
      wb(1'b0, 12'h200, 32'h0, 4'hf);
      chk(irq, 32'h0);
      hit(4'h3);
      chk(irq, 32'h1);
      wb(1'b0, 12'h200, 32'h0, 4'hf);
      chk(rd[0], 32'h1);
      chk(irq, 32'h0);
      wb(1'b1, 12'h204, 32'h0, 4'hf);
      hit(4'h1);
      chk(irq, 32'h0);
    end
  endtask
  task t_gate;
    begin
      dv <= 1'b1;
      lvl <= 12'd479;
      repeat (2) @(posedge clk);
      chk(rel, 32'h0);
      lvl <= 12'd480;
      repeat (2) @(posedge clk);
      chk(rel, 32'h1);
      pkt <= 1'b1;
      @(posedge clk);
      pkt <= 1'b0;
      lvl <= 12'd0;
      repeat (2) @(posedge clk);
      chk(rel, 32'h1);
      for (i = 0; i < 4; i = i + 1) begin
        wb(1'b1, 12'h0f8, 32'h8000 | (i << 12), 4'hf);
        lvl <= 12'd479 + i * 128;
        repeat (2) @(posedge clk);
        chk(rel, 32'h0);
        lvl <= 12'd480 + i * 128;
        repeat (2) @(posedge clk);
        chk(rel, 32'h1);
      end
      dv <= 1'b0;
      lvl <= 12'd0;
      repeat (2) @(posedge clk);
      chk(rel, 32'h1);
      wb(1'b1, 12'h204, 32'h2, 4'hf);
      chk(irq, 32'h1);
      wb(1'b0, 12'h200, 32'h0, 4'hf);
      chk(rd, 32'h3);
      chk(irq, 32'h0);
      wb(1'b0, 12'h208, 32'h0, 4'hf);
      chk(rd, 32'h0004_000d);
    end
  endtask
  task t_reset;
    begin
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      wb(1'b0, 12'h0f8, 32'h0, 4'hf);
      chk(rd, 32'h0);
      wb(1'b0, 12'h208, 32'h0, 4'hf);
      chk(rd, 32'h0);
    end
  endtask
  task print_verdict;
    begin
      if (errors == 0 && n_compared > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    errors = errors + 1;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_codes;
    t_irq;
    t_gate;
    t_reset;
    print_verdict;
  end
endmodule // fmc_top_tb_top
